// ==== uw_pkg.sv ====
// Constants, field positions and state types of the serial port block
// Assumes one 100 MHz clock; all users refer to names as uw_pkg::name
package uw_pkg;
  // ==========================================================
  // Sizes and timing
  localparam int              DEPTH     = 4;
  localparam int              PW        = $clog2(DEPTH);
  localparam int              CW        = PW + 1;
  localparam logic [CW-1:0]   DEPTH_C   = CW'(DEPTH);
  localparam logic [CW-1:0]   RTS_LIMIT = CW'(DEPTH - 2);
  localparam logic [15:0]     DEPTH_OFS = 16'(DEPTH);
  localparam logic [2:0]      OVS_LAST  = 3'h7;
  localparam logic [2:0]      OVS_MID   = 3'h3;
  localparam logic [17:0]     OVS_STEP  = 18'h00008;
  localparam logic [15:0]     MIN_DIV   = 16'h0008;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0]      A_DATA = 8'h00;
  localparam logic [7:0]      A_STAT = 8'h04;
  localparam logic [7:0]      A_CFG  = 8'h08;
  localparam logic [7:0]      A_IDIV = 8'h0c;
  localparam logic [7:0]      A_FDIV = 8'h10;
  localparam logic [7:0]      A_EVT  = 8'h14;
  localparam logic [7:0]      A_IEN  = 8'h18;
  localparam logic [7:0]      A_CTL  = 8'h1c;
  localparam logic [7:0]      A_ERRA = 8'h20;
  localparam logic [7:0]      A_ERRB = 8'h24;
  // ==========================================================
  // Reset values
  localparam logic [6:0]      CFG_RST  = 7'h00;
  localparam logic [15:0]     IDIV_RST = 16'h0008;
  localparam logic [9:0]      IEN_RST  = 10'h000;
  localparam logic [1:0]      CTL_RST  = 2'h0;
  localparam logic [2:0]      LVL_RST  = 3'h3;
  // ==========================================================
  // Field positions
  localparam int C_RTS = 0, C_8BIT = 1, C_2STP = 2, C_PAR = 3;
  localparam int C_ODD = 4, C_FLOW = 5, C_AUTO = 6;
  localparam int K_TOPEN = 0, K_MODE = 1, K_RXRST = 2;
  localparam int E_TXBUF = 3, E_RXBUF = 5, E_PAR = 7, E_FRM = 8, E_OVR = 9;
  localparam int ERR_VBIT = 16;
  localparam logic [1:0]      RESP_OK  = 2'h0;
  localparam logic [1:0]      RESP_ERR = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} uw_ser_t;

  typedef struct packed {
    logic       par;
    logic       frm;
    logic [7:0] data;
  } uw_rx_ent_t;

  typedef struct packed {
    logic [6:0]                  cfg;
    logic [15:0]                 idiv;
    logic                        fdiv;
    logic [1:0]                  ctl;
    logic [9:0]                  ien;
    logic [9:0]                  ev;
    logic [2:0]                  lvl_prev;
    logic [3:0]                  act_prev;
    logic                        irq;
    logic [1:0]                  err_v;
    logic [1:0][15:0]            err_off;
    logic [17:0]                 acc;
    logic                        tick;
    logic [DEPTH-1:0][7:0]       tx_mem;
    logic [PW-1:0]               tx_wp;
    logic [PW-1:0]               tx_rp;
    logic [CW-1:0]               tx_cnt;
    uw_ser_t                     tx_st;
    logic [2:0]                  tx_bit;
    logic [2:0]                  tx_tck;
    logic [7:0]                  tx_sh;
    logic                        txd;
    uw_rx_ent_t [DEPTH-1:0]      rx_mem;
    logic [PW-1:0]               rx_wp;
    logic [PW-1:0]               rx_rp;
    logic [CW-1:0]               rx_cnt;
    uw_ser_t                     rx_st;
    logic [2:0]                  rx_bit;
    logic [2:0]                  rx_tck;
    logic [7:0]                  rx_sh;
    logic                        rx_par;
    logic                        rx_ovf;
    logic                        rts_n;
    logic                        awready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    logic                        dma_tx_ready;
    logic                        dma_rx_valid;
    uw_rx_ent_t                  dma_rx_data;
  } uw_state_t;
endpackage

// ==== uw_uart.sv ====
// Serial port with 4-entry FIFOs, handshake lines, DMA ports and AXI4-Lite registers
// Assumes all inputs synchronous to clk; DMA engine drives buffer flags and offsets
//
// Notes on behaviour
// - Seven data bits when clear, eight when set
// - Send one or two stops; receive needs one
// - Parity enable adds a parity bit both ways
// - Even is XOR of data; odd inverts it
// - Start, data LSB first, parity, then stops
// - Line idles high; start bit drives low
// - Four-entry FIFOs; data write pushes transmit
// - Data read pops oldest received character
// - DMA also pushes transmit and pops receive
// - With handshake, start only when clear-to-send low
// - Character in progress always finishes
// - With handshake, auto request low while two slots free
// - Otherwise request follows software bit
// - Without handshake, clear-to-send ignored
// - DMA pop records first error offset
// - Overrun flags at once, offset four ahead
// - Error record cleared by reset or reload
// - Level events fire on edge or level
// - Buffer complete on active flag falling
// - Parity, frame and overrun events raised
// - Interrupt needs event enable and top enable
// - Fractional divider, eight ticks, minimum eight
// - Overflow flag set on arrival when full, cleared by data read
`timescale 1ns/100ps
module uw_uart (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Serial pins
  output logic             txd,
  input  wire logic        rxd,
  output logic             request_to_send_n,
  input  wire logic        clear_to_send_n,
  // DMA side
  input  wire logic [7:0]  dma_tx_data,
  input  wire logic        dma_tx_valid,
  output logic             dma_tx_ready,
  output logic [9:0]       dma_rx_data,
  output logic             dma_rx_valid,
  input  wire logic        dma_rx_ready,
  input  wire logic        dma_rx_buf,
  input  wire logic [15:0] dma_rx_offset,
  input  wire logic [1:0]  tx_buf_active_ab,
  input  wire logic [1:0]  rx_buf_active_ab,
  // Interrupt
  output logic             serial_top_irq
);

  uw_pkg::uw_state_t  s;
  uw_pkg::uw_state_t  n;
  uw_pkg::uw_rx_ent_t head;
  uw_pkg::uw_rx_ent_t ent;
  logic [31:0]        mask;
  logic [31:0]        wm;
  logic [17:0]        div;
  logic [17:0]        sum;
  logic [15:0]        idiv_eff;
  logic [9:0]         evset;
  logic [2:0]         lvl;
  logic [3:0]         act;
  logic [7:0]         dmask;
  logic [2:0]         last;
  logic               w_go;
  logic               r_go;
  logic               pop_bus;
  logic               pop_dma;
  logic               tx_ok;
  logic               txidle;

  // ==========================================================
  // Next state
  always_comb begin
    n        = s;
    mask     = '0;
    evset    = '0;
    ent      = '0;
    head     = s.rx_mem[s.rx_rp];
    w_go     = s.awready & awvalid & wvalid;
    r_go     = s.arready & arvalid;
    pop_bus  = r_go && (araddr == uw_pkg::A_DATA);
    pop_dma  = s.dma_rx_valid & dma_rx_ready;
    dmask    = s.cfg[uw_pkg::C_8BIT] ? 8'hff : 8'h7f;
    last     = s.cfg[uw_pkg::C_8BIT] ? 3'h7 : 3'h6;
    txidle   = (s.tx_cnt == '0) && (s.tx_st == uw_pkg::ST_IDLE);
    lvl      = {s.rx_cnt != '0, s.tx_cnt != uw_pkg::DEPTH_C, txidle};
    act      = {rx_buf_active_ab, tx_buf_active_ab};
    tx_ok    = !s.cfg[uw_pkg::C_FLOW] || !clear_to_send_n;

    // Fractional baud generator, eight ticks per bit
    idiv_eff = (s.idiv < uw_pkg::MIN_DIV) ? uw_pkg::MIN_DIV : s.idiv;
    div      = {1'b0, idiv_eff, 1'b0} + {17'h0, s.fdiv};
    sum      = s.acc + uw_pkg::OVS_STEP;
    n.tick   = 1'b0;
    n.acc    = sum;
    if (sum >= div) begin
      n.tick = 1'b1;
      n.acc  = sum - div;
    end

    // Bus handshakes
    n.awready = awvalid & wvalid & ~s.awready & ~s.bvalid;
    n.arready = arvalid & ~s.arready & ~s.rvalid;
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      mask[8*i +: 8] = {8{wstrb[i]}};
    end
    wm = wdata & mask;

    // Receive FIFO pops
    if ((pop_bus && s.rx_cnt != '0) || pop_dma) begin
      n.rx_rp  = s.rx_rp + 1'b1;
      n.rx_cnt = s.rx_cnt - 1'b1;
    end
    if (pop_bus) begin
      n.rx_ovf = 1'b0;
    end

    // Error offset records
    for (int b = 0; b < 2; b++) begin
      if ((w_go && awaddr == uw_pkg::A_CTL && wm[uw_pkg::K_RXRST])
          || (rx_buf_active_ab[b] && !s.act_prev[2+b])) begin
        n.err_v[b] = 1'b0;
      end
    end
    if (pop_dma && (head.par || head.frm) && !n.err_v[dma_rx_buf]) begin
      n.err_v[dma_rx_buf]   = 1'b1;
      n.err_off[dma_rx_buf] = dma_rx_offset;
    end

    // Register reads
    if (r_go) begin
      n.rvalid = 1'b1;
      n.rresp  = uw_pkg::RESP_OK;
      n.rdata  = '0;
      case (araddr)
        uw_pkg::A_DATA: begin
          if (s.rx_cnt != '0) begin
            n.rdata = {24'h0, head.data};
          end
        end
        uw_pkg::A_STAT: begin
          n.rdata[6:0] = {txidle, (s.rx_cnt != '0) && head.par,
                          (s.rx_cnt != '0) && head.frm, s.rx_ovf,
                          s.tx_cnt != uw_pkg::DEPTH_C, s.rx_cnt != '0,
                          !clear_to_send_n};
        end
        uw_pkg::A_CFG:  n.rdata[6:0] = s.cfg;
        uw_pkg::A_IDIV: n.rdata[15:0] = s.idiv;
        uw_pkg::A_FDIV: n.rdata[0] = s.fdiv;
        uw_pkg::A_EVT:  n.rdata[9:0] = s.ev;
        uw_pkg::A_IEN:  n.rdata[9:0] = s.ien;
        uw_pkg::A_CTL:  n.rdata[1:0] = s.ctl;
        uw_pkg::A_ERRA: n.rdata[16:0] = {s.err_v[0], s.err_off[0]};
        uw_pkg::A_ERRB: n.rdata[16:0] = {s.err_v[1], s.err_off[1]};
        default:        n.rresp = uw_pkg::RESP_ERR;
      endcase
    end

    // Register writes
    if (w_go) begin
      n.bvalid = 1'b1;
      n.bresp  = uw_pkg::RESP_OK;
      case (awaddr)
        uw_pkg::A_DATA: begin
          if (wstrb[0] && s.tx_cnt != uw_pkg::DEPTH_C) begin
            n.tx_mem[s.tx_wp] = wdata[7:0];
            n.tx_wp           = s.tx_wp + 1'b1;
            n.tx_cnt          = n.tx_cnt + 1'b1;
          end
        end
        uw_pkg::A_STAT, uw_pkg::A_ERRA, uw_pkg::A_ERRB: begin
        end
        uw_pkg::A_CFG:  n.cfg  = (s.cfg & ~mask[6:0]) | wm[6:0];
        uw_pkg::A_IDIV: n.idiv = (s.idiv & ~mask[15:0]) | wm[15:0];
        uw_pkg::A_FDIV: n.fdiv = (s.fdiv & ~mask[0]) | wm[0];
        uw_pkg::A_EVT:  n.ev   = s.ev & ~wm[9:0];
        uw_pkg::A_IEN:  n.ien  = (s.ien & ~mask[9:0]) | wm[9:0];
        uw_pkg::A_CTL:  n.ctl  = (s.ctl & ~mask[1:0]) | wm[1:0];
        default:        n.bresp = uw_pkg::RESP_ERR;
      endcase
    end
    if (s.dma_tx_ready && dma_tx_valid) begin
      n.tx_mem[s.tx_wp] = dma_tx_data;
      n.tx_wp           = s.tx_wp + 1'b1;
      n.tx_cnt          = n.tx_cnt + 1'b1;
    end

    // ==========================================================
    // Transmitter
    if (s.tick) begin
      if (s.tx_st == uw_pkg::ST_IDLE) begin
        if (s.tx_cnt != '0 && tx_ok) begin
          n.tx_sh  = s.tx_mem[s.tx_rp] & dmask;
          n.tx_rp  = s.tx_rp + 1'b1;
          n.tx_cnt = n.tx_cnt - 1'b1;
          n.tx_st  = uw_pkg::ST_START;
          n.tx_tck = '0;
          n.txd    = 1'b0;
        end
      end else begin
        n.tx_tck = s.tx_tck + 1'b1;
        if (s.tx_tck == uw_pkg::OVS_LAST) begin
          case (s.tx_st)
            uw_pkg::ST_START: begin
              n.tx_st  = uw_pkg::ST_DATA;
              n.tx_bit = '0;
              n.txd    = s.tx_sh[0];
            end
            uw_pkg::ST_DATA: begin
              if (s.tx_bit != last) begin
                n.tx_bit = s.tx_bit + 1'b1;
                n.txd    = s.tx_sh[n.tx_bit];
              end else if (s.cfg[uw_pkg::C_PAR]) begin
                n.tx_st = uw_pkg::ST_PAR;
                n.txd   = (^s.tx_sh) ^ s.cfg[uw_pkg::C_ODD];
              end else begin
                n.tx_st  = uw_pkg::ST_STOP;
                n.tx_bit = '0;
                n.txd    = 1'b1;
              end
            end
            uw_pkg::ST_PAR: begin
              n.tx_st  = uw_pkg::ST_STOP;
              n.tx_bit = '0;
              n.txd    = 1'b1;
            end
            uw_pkg::ST_STOP: begin
              if (s.tx_bit == '0 && s.cfg[uw_pkg::C_2STP]) begin
                n.tx_bit = 3'h1;
              end else begin
                n.tx_st = uw_pkg::ST_IDLE;
              end
            end
            default: n.tx_st = uw_pkg::ST_IDLE;
          endcase
        end
      end
    end

    // ==========================================================
    // Receiver
    if (s.tick) begin
      case (s.rx_st)
        uw_pkg::ST_IDLE: begin
          if (!rxd) begin
            n.rx_st  = uw_pkg::ST_START;
            n.rx_tck = '0;
          end
        end
        uw_pkg::ST_START: begin
          n.rx_tck = s.rx_tck + 1'b1;
          if (s.rx_tck == uw_pkg::OVS_MID) begin
            n.rx_st  = rxd ? uw_pkg::ST_IDLE : uw_pkg::ST_DATA;
            n.rx_tck = '0;
            n.rx_bit = '0;
            n.rx_sh  = '0;
          end
        end
        default: begin
          n.rx_tck = s.rx_tck + 1'b1;
          if (s.rx_tck == uw_pkg::OVS_LAST) begin
            case (s.rx_st)
              uw_pkg::ST_DATA: begin
                n.rx_sh[s.rx_bit] = rxd;
                n.rx_bit          = s.rx_bit + 1'b1;
                if (s.rx_bit == last) begin
                  n.rx_st = s.cfg[uw_pkg::C_PAR] ? uw_pkg::ST_PAR : uw_pkg::ST_STOP;
                end
              end
              uw_pkg::ST_PAR: begin
                n.rx_par = rxd;
                n.rx_st  = uw_pkg::ST_STOP;
              end
              default: begin
                n.rx_st  = uw_pkg::ST_IDLE;
                ent.data = s.rx_sh & dmask;
                ent.frm  = !rxd;
                ent.par  = s.cfg[uw_pkg::C_PAR]
                           && (s.rx_par != ((^ent.data) ^ s.cfg[uw_pkg::C_ODD]));
                evset[uw_pkg::E_PAR] = ent.par;
                evset[uw_pkg::E_FRM] = ent.frm;
                if (n.rx_cnt == uw_pkg::DEPTH_C) begin
                  n.rx_ovf             = 1'b1;
                  evset[uw_pkg::E_OVR] = 1'b1;
                  if (rx_buf_active_ab[dma_rx_buf] && !n.err_v[dma_rx_buf]) begin
                    n.err_v[dma_rx_buf]   = 1'b1;
                    n.err_off[dma_rx_buf] = dma_rx_offset + uw_pkg::DEPTH_OFS;
                  end
                end else begin
                  n.rx_mem[s.rx_wp] = ent;
                  n.rx_wp           = s.rx_wp + 1'b1;
                  n.rx_cnt          = n.rx_cnt + 1'b1;
                end
              end
            endcase
          end
        end
      endcase
    end

    // ==========================================================
    // Events and interrupt
    evset[2:0] = s.ctl[uw_pkg::K_MODE] ? lvl : (lvl & ~s.lvl_prev);
    evset[uw_pkg::E_RXBUF +: 2] = s.act_prev[3:2] & ~act[3:2];
    evset[uw_pkg::E_TXBUF +: 2] = s.act_prev[1:0] & ~act[1:0];
    n.lvl_prev = lvl;
    n.act_prev = act;
    n.ev       = n.ev | evset;
    n.irq      = n.ctl[uw_pkg::K_TOPEN] & (|(n.ev & n.ien));

    // Pins and DMA handshakes
    if (n.cfg[uw_pkg::C_AUTO] && n.cfg[uw_pkg::C_FLOW]) begin
      n.rts_n = !(n.rx_cnt <= uw_pkg::RTS_LIMIT);
    end else begin
      n.rts_n = !n.cfg[uw_pkg::C_RTS];
    end
    n.dma_tx_ready = (n.tx_cnt != uw_pkg::DEPTH_C) && !n.awready;
    n.dma_rx_valid = (n.rx_cnt != '0) && !n.arready;
    n.dma_rx_data  = n.rx_mem[n.rx_rp];
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s          <= '0;
      s.cfg      <= uw_pkg::CFG_RST;
      s.idiv     <= uw_pkg::IDIV_RST;
      s.ien      <= uw_pkg::IEN_RST;
      s.ctl      <= uw_pkg::CTL_RST;
      s.lvl_prev <= uw_pkg::LVL_RST;
      s.txd      <= 1'b1;
      s.rts_n    <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign awready           = s.awready;
  assign wready            = s.awready;
  assign bvalid            = s.bvalid;
  assign bresp             = s.bresp;
  assign arready           = s.arready;
  assign rvalid            = s.rvalid;
  assign rdata             = s.rdata;
  assign rresp             = s.rresp;
  assign txd               = s.txd;
  assign request_to_send_n = s.rts_n;
  assign dma_tx_ready      = s.dma_tx_ready;
  assign dma_rx_valid      = s.dma_rx_valid;
  assign dma_rx_data       = s.dma_rx_data;
  assign serial_top_irq    = s.irq;

endmodule // uw_uart

// ==== uw_uart_properties.sv ====
// Checker for bus handshakes, reset levels and serial line timing at the ports
// Assumes binding into uw_uart with a bit time of at least 16 clocks
`timescale 1ns/100ps
module uw_uart_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register bus
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic [1:0]  bresp,
  input wire logic        bready,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic        rready,
  // Pins
  input wire logic        txd,
  input wire logic        request_to_send_n,
  input wire logic        dma_tx_ready,
  input wire logic        serial_top_irq
);
  // ==========================================================
  // Sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_take;
    awready && wready;
  endsequence
  sequence s_rd_take;
    arready;
  endsequence
  // ==========================================================
  // Properties
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> txd && request_to_send_n
    && !bvalid && !rvalid && !serial_top_irq && !dma_tx_ready) else $error("reset levels wrong");
  a_aw_pulse: assert property (s_wr_take |=> !awready && !wready)
    else $error("write accept longer than one cycle");
  a_wr_resp: assert property (s_wr_take |=> bvalid) else $error("write response late");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rd_resp: assert property (s_rd_take |=> rvalid && !arready) else $error("read response late");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_low_bit_len: assert property ($fell(txd) |-> !txd [*8])
    else $error("low bit too short");
  a_high_bit_len: assert property ($rose(txd) |-> txd [*8])
    else $error("high bit too short");
  a_dma_tx_block: assert property (awready |-> !dma_tx_ready)
    else $error("dma push during bus write");
endmodule // uw_uart_properties

// ==== uw_serial_peer.sv ====
// Far-side serial device: sends frames on rxd and samples frames from txd
// Assumes BIT clock cycles per bit; line idles high between frames
`timescale 1ns/100ps
module uw_serial_peer #(parameter int BIT = 16) (
  // Clock
  input  wire logic clk,
  // Serial pins
  input  wire logic txd,
  output logic      rxd,
  input  wire logic request_to_send_n,
  output logic      clear_to_send_n
);
  logic [11:0] got;
  initial begin
    rxd = 1'b1;
    clear_to_send_n = 1'b0;
  end
  // Drive a frame of n bits, first bit first, then idle high
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (BIT) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  // Wait for a start bit, then sample n bits at mid bit
  task automatic recv(input int n, output logic ok);
    got = 12'h000;
    ok = 1'b0;
    for (int t = 0; t < 4000 && !ok; t++) begin
      @(posedge clk);
      ok = !txd;
    end
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      got[i] = txd;
      repeat (BIT) @(posedge clk);
    end
  endtask
  task automatic cts(input logic v);
    clear_to_send_n <= v;
  endtask
endmodule // uw_serial_peer

// ==== uart_with_flow_control_test.sv ====
// Testbench: register bus, frame formats, handshake, DMA and event checks
// Assumes uw_pkg, uw_uart, uw_serial_peer and the checker compiled first
`timescale 1ns/100ps
module uart_with_flow_control_test;
  // ==========================================================
  // Signals
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [7:0]  dma_tx_data = 8'h00;
  logic        dma_tx_valid = 1'b0;
  logic        dma_rx_ready = 1'b0;
  logic        dma_rx_buf = 1'b0;
  logic [15:0] dma_rx_offset = 16'h0;
  logic [1:0]  tx_buf_active_ab = 2'h0;
  logic [1:0]  rx_buf_active_ab = 2'h0;
  logic        awready, wready, bvalid, arready, rvalid, rxd, txd, request_to_send_n;
  logic        clear_to_send_n, dma_tx_ready, dma_rx_valid, serial_top_irq;
  logic [1:0]  bresp, rresp, rr;
  logic [31:0] rdata, rv;
  logic [9:0]  dma_rx_data;
  logic [6:0]  cfgs [6] = '{7'h02, 7'h00, 7'h0e, 7'h18, 7'h1a, 7'h14};
  int          fails = 0;
  int          n_compared = 0;
  localparam logic [1:0] OK = uw_pkg::RESP_OK;
  always #5 clk = ~clk;
  uw_uart u_dut (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .txd, .rxd, .request_to_send_n, .clear_to_send_n, .dma_tx_data, .dma_tx_valid,
    .dma_tx_ready, .dma_rx_data, .dma_rx_valid, .dma_rx_ready, .dma_rx_buf, .dma_rx_offset,
    .tx_buf_active_ab, .rx_buf_active_ab, .serial_top_irq);
  uw_serial_peer #(.BIT(16)) u_peer (.clk, .txd, .rxd, .request_to_send_n, .clear_to_send_n);
  // ==========================================================
  // Tasks
  task automatic stop_test();
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic limit(input int t);
    if (t >= 50) begin
      fails++;
      stop_test();
    end
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int t;
    t = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1 && ++t < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1 && ++t < 50);
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
    limit(t);
    chk({30'h0, bresp}, {30'h0, e});
  endtask
  task automatic rd(input logic [7:0] a);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1 && ++t < 50);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1 && ++t < 50);
    rv = rdata;
    rr = rresp;
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
    limit(t);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
    chk({30'h0, rr}, {30'h0, OK});
  endtask
  task automatic pins_are(input logic q, input logic s);
    repeat (3) @(posedge clk);
    chk({30'h0, serial_top_irq, request_to_send_n}, {30'h0, q, s});
  endtask
  function automatic logic [15:0] frame(input logic [6:0] c, input logic [7:0] d);
    logic [11:0] b;
    int          k;
    b = 12'hffe;
    k = 1;
    for (int i = 0; i < (c[1] ? 8 : 7); i++) begin
      b[k] = d[i];
      k++;
    end
    if (c[3]) begin
      b[k] = ^(d & (c[1] ? 8'hff : 8'h7f)) ^ c[4];
      k++;
    end
    k += c[2] ? 2 : 1;
    return {4'(k), b};
  endfunction
  task automatic tx_frame(input logic [6:0] c, input logic [7:0] d);
    logic [15:0] f;
    logic        ok;
    f = frame(c, d);
    u_peer.recv(int'(f[15:12]), ok);
    chk({31'h0, ok}, 32'h1);
    chk({20'h0, u_peer.got}, {20'h0, f[11:0] & ((12'h1 << f[15:12]) - 12'h1)});
  endtask
  task automatic rx_chk(input logic [6:0] c, input logic [7:0] d, input logic [11:0] e,
                        input logic [31:0] st, input logic [31:0] x);
    logic [15:0] f;
    wr(uw_pkg::A_CFG, {25'h0, c}, OK);
    f = frame(c & 7'h7b, d);
    u_peer.send(f[11:0] ^ e, int'(f[15:12]));
    rdc(uw_pkg::A_STAT, st);
    rdc(uw_pkg::A_DATA, x);
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    stop_test();
  end
  initial begin
    int t;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(uw_pkg::A_STAT, 32'h45);
    rdc(uw_pkg::A_IDIV, 32'h8);
    wr(8'h28, 32'h0, uw_pkg::RESP_ERR);
    rd(8'h28);
    chk({30'h0, rr}, {30'h0, uw_pkg::RESP_ERR});
    foreach (cfgs[i]) begin
      wr(uw_pkg::A_CFG, {25'h0, cfgs[i]}, OK);
      wr(uw_pkg::A_DATA, 32'ha5 ^ i, OK);
      tx_frame(cfgs[i], 8'ha5 ^ 8'(i));
    end
    rx_chk(7'h1a, 8'h3c, 12'h000, 32'h47, 32'h3c);
    rx_chk(7'h1a, 8'h96, 12'h200, 32'h67, 32'h96);
    rx_chk(7'h1a, 8'h5b, 12'h400, 32'h57, 32'h5b);
    rx_chk(7'h00, 8'hd5, 12'h000, 32'h47, 32'h55);
    wr(uw_pkg::A_CFG, 32'h62, OK);
    for (int i = 0; i < 5; i++) begin
      u_peer.send(12'(frame(7'h62, 8'h10 + 8'(i))), 10);
      pins_are(1'b0, i > 1);
    end
    rdc(uw_pkg::A_STAT, 32'h4f);
    for (int i = 0; i < 4; i++) rdc(uw_pkg::A_DATA, 32'h10 + i);
    rdc(uw_pkg::A_STAT, 32'h45);
    rdc(uw_pkg::A_DATA, 32'h0);
    wr(uw_pkg::A_CFG, 32'h21, OK);
    pins_are(1'b0, 1'b0);
    wr(uw_pkg::A_CFG, 32'h22, OK);
    pins_are(1'b0, 1'b1);
    u_peer.cts(1'b1);
    wr(uw_pkg::A_DATA, 32'h5a, OK);
    repeat (64) @(posedge clk);
    chk({31'h0, txd}, 32'h1);
    u_peer.cts(1'b0);
    tx_frame(7'h22, 8'h5a);
    wr(uw_pkg::A_DATA, 32'hc3, OK);
    fork
      tx_frame(7'h22, 8'hc3);
      begin
        repeat (40) @(posedge clk);
        u_peer.cts(1'b1);
      end
    join
    wr(uw_pkg::A_CFG, 32'h02, OK);
    wr(uw_pkg::A_DATA, 32'h3e, OK);
    tx_frame(7'h02, 8'h3e);
    u_peer.cts(1'b0);
    dma_tx_data <= 8'h77;
    dma_tx_valid <= 1'b1;
    t = 0;
    do @(posedge clk); while (dma_tx_ready !== 1'b1 && ++t < 50);
    dma_tx_valid <= 1'b0;
    limit(t);
    tx_frame(7'h02, 8'h77);
    wr(uw_pkg::A_CFG, 32'h0a, OK);
    rx_buf_active_ab <= 2'b01;
    dma_rx_offset <= 16'h0005;
    u_peer.send(12'(frame(7'h0a, 8'h81)) ^ 12'h200, 11);
    dma_rx_ready <= 1'b1;
    t = 0;
    do @(posedge clk); while (dma_rx_valid !== 1'b1 && ++t < 50);
    dma_rx_ready <= 1'b0;
    limit(t);
    chk({22'h0, dma_rx_data}, 32'h281);
    rdc(uw_pkg::A_ERRA, 32'h10005);
    wr(uw_pkg::A_CTL, 32'h4, OK);
    rd(uw_pkg::A_ERRA);
    chk(rv & 32'h10000, 32'h0);
    wr(uw_pkg::A_IEN, 32'h80, OK);
    pins_are(1'b0, 1'b1);
    wr(uw_pkg::A_CTL, 32'h1, OK);
    pins_are(1'b1, 1'b1);
    wr(uw_pkg::A_EVT, 32'h3ff, OK);
    pins_are(1'b0, 1'b1);
    tx_buf_active_ab <= 2'b10;
    wr(uw_pkg::A_IEN, 32'h10, OK);
    tx_buf_active_ab <= 2'b00;
    pins_are(1'b1, 1'b1);
    wr(uw_pkg::A_CTL, 32'h3, OK);
    wr(uw_pkg::A_IEN, 32'h1, OK);
    wr(uw_pkg::A_EVT, 32'h3ff, OK);
    pins_are(1'b1, 1'b1);
    stop_test();
  end
endmodule // uart_with_flow_control_test
bind uw_uart uw_uart_properties u_props (.clk, .rst_n, .awready, .wready, .bvalid, .bresp,
  .bready, .arready, .rvalid, .rdata, .rready, .txd, .request_to_send_n, .dma_tx_ready,
  .serial_top_irq);
